// [verilog/shi_host.sv]
`timescale 1ns/1ps
`include "shi_cfg.svh"
// Behaviour
// - Initiator asserts ACK only after REQ, releases it after REQ drops.
// - Target starts each handshake with REQ and drops it on ACK.
// - Only the target drives I/O; it sets direction and selection type.
// - Only the target drives C/D: low data phase, high control phase.
// - SEL selects a target, or lets a target reselect an initiator.
// - ATN driven only by the initiator after successful selection.
// - BSY shows the bus in use; either party may drive it.
// - Acknowledge with a strobe selects data; chip select stays high.
// - Normal byte ends as acknowledge rises; burst byte ends with strobe.
// - End-of-process blocks more cycles; host clears DMA enable itself.
module shi_host
    import shi_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    input  wire logic [7:0]    sw_addr,
    input  wire logic [31:0]   sw_wdata,
    input  wire logic          sw_wr,
    input  wire logic          sw_rd,
    output logic      [31:0]   sw_rdata,
    input  wire shi_dev_in_t   dev_in,
    output shi_dev_out_t       dev_out
);

    shi_state_t    state_reg;
    shi_state_t    state_next;
    logic [7:0]    cnt_reg;
    logic [7:0]    cnt_next;
    logic          dma_reg;
    logic          dma_next;
    logic          is_wr_reg;
    logic          is_wr_next;
    logic          burst_on_reg;
    logic [4:0]    rem_reg;
    logic [3:0]    idx_reg;
    logic [3:0]    dev_addr_reg;
    logic [7:0]    dev_wdata_reg;
    logic [7:0]    rdata_reg;
    logic [2:0]    cfg_reg;
    logic          done_reg;
    shi_dev_in_t   in_reg;
    shi_dev_out_t  pins_next;
    logic [7:0]    buf_mem [0:`SHI_BUF_DEPTH-1];

    logic          wr_ctrl;
    logic          wr_go;
    logic          rd_go;
    logic          rst_go;
    logic          dma_go;
    logic          abort;
    logic          strobe_end;
    logic          byte_end;
    logic          done_evt;
    logic          last_byte;
    logic          dma_ok;
    logic          buf_sel;
    logic          in_cycle;

    assign wr_ctrl    = sw_wr && (sw_addr == `SHI_SW_CTRL);
    assign wr_go      = wr_ctrl && sw_wdata[`SHI_CTRL_WR_GO];
    assign rd_go      = wr_ctrl && sw_wdata[`SHI_CTRL_RD_GO];
    assign rst_go     = wr_ctrl && sw_wdata[`SHI_CTRL_RST_GO];
    assign dma_go     = wr_ctrl && sw_wdata[`SHI_CTRL_DMA_GO];
    assign abort      = wr_ctrl && sw_wdata[`SHI_CTRL_ABORT];
    assign strobe_end = (state_reg == SHI_ST_STB) && (cnt_reg == 8'h00);
    assign byte_end   = (state_reg == SHI_ST_HOLD) && (cnt_reg == 8'h00);
    assign last_byte  = (rem_reg == 5'h01);
    assign buf_sel    = (sw_addr & `SHI_SW_BUF_MASK) == `SHI_SW_BUF_BASE;
    assign done_evt   = byte_end && (!dma_reg || last_byte);

    // Normal DMA waits for a request; burst waits on ready once acknowledged
    assign dma_ok = (cfg_reg[`SHI_CFG_BURST] && burst_on_reg) ?
                    in_reg.ready :
                    in_reg.transfer_request;

    // Inputs are registered once before any decision looks at them
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_reg <= '0;
        end else begin
            in_reg <= dev_in;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next   = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
        dma_next   = dma_reg;
        is_wr_next = is_wr_reg;
        unique case (state_reg)
            SHI_ST_RST: begin
                if (cnt_reg == 8'h00) begin
                    state_next = SHI_ST_IDLE;
                end
            end
            SHI_ST_IDLE: begin
                if (rst_go) begin
                    state_next = SHI_ST_RST;
                    cnt_next   = 8'(`SHI_RST_CYC - 1);
                end else if (wr_go || rd_go) begin
                    state_next = SHI_ST_SETUP;
                    cnt_next   = 8'(`SHI_SETUP_CYC - 1);
                    dma_next   = 1'b0;
                    is_wr_next = wr_go;
                end else if (dma_go && (rem_reg != 5'h00)) begin
                    state_next = SHI_ST_DWAIT;
                    dma_next   = 1'b1;
                    is_wr_next = !cfg_reg[`SHI_CFG_DIR_RD];
                end
            end
            SHI_ST_DWAIT: begin
                if (abort) begin
                    state_next = SHI_ST_IDLE;
                end else if (dma_ok) begin
                    state_next = SHI_ST_SETUP;
                    cnt_next   = 8'(`SHI_SETUP_CYC - 1);
                end
            end
            SHI_ST_SETUP: begin
                if (cnt_reg == 8'h00) begin
                    state_next = SHI_ST_STB;
                    cnt_next   = 8'(`SHI_STB_CYC - 1);
                end
            end
            SHI_ST_STB: begin
                if (cnt_reg == 8'h00) begin
                    state_next = SHI_ST_HOLD;
                    cnt_next   = 8'(`SHI_HOLD_CYC - 1);
                end
            end
            SHI_ST_HOLD: begin
                if (cnt_reg == 8'h00) begin
                    // After an end-of-process byte no further cycle is run
                    if (!dma_reg || last_byte) begin
                        state_next = SHI_ST_IDLE;
                    end else begin
                        state_next = SHI_ST_DWAIT;
                    end
                end
            end
            default: begin
                state_next = SHI_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SHI_ST_RST;
            cnt_reg   <= 8'(`SHI_RST_CYC - 1);
            dma_reg   <= 1'b0;
            is_wr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            dma_reg   <= dma_next;
            is_wr_reg <= is_wr_next;
        end
    end

    // Pin image follows the next state so the pins line up with state_reg
    always_comb begin
        in_cycle  = (state_next == SHI_ST_SETUP) ||
                    (state_next == SHI_ST_STB) ||
                    (state_next == SHI_ST_HOLD);
        pins_next = '0;
        pins_next.chip_reset = (state_next == SHI_ST_RST);
        // Data accesses under acknowledge leave chip select high
        pins_next.cs_n = !(in_cycle && !dma_next);
        pins_next.register_select = dma_next ?
                                    `SHI_DEV_DATA :
                                    dev_addr_reg[2:0];
        // Strobe type acts as the fourth address bit
        pins_next.host_read_strobe_n  =
            !((state_next == SHI_ST_STB) && !is_wr_next);
        pins_next.host_write_strobe_n =
            !((state_next == SHI_ST_STB) && is_wr_next);
        // Normal: acknowledge rises after the strobe, ending the byte.
        // Burst: acknowledge stays low between bytes, even as one ends.
        pins_next.transfer_acknowledge_n =
            !(dma_next && (in_cycle ||
              ((state_next == SHI_ST_DWAIT) &&
               (burst_on_reg || byte_end) &&
               cfg_reg[`SHI_CFG_BURST])));
        pins_next.end_of_process_n =
            !((state_next == SHI_ST_STB) && dma_next && last_byte &&
              cfg_reg[`SHI_CFG_FIN_LAST]);
        pins_next.host_data_oe = in_cycle && is_wr_next;
        pins_next.host_data_o  = dma_next ? buf_mem[idx_reg] :
                                 dev_wdata_reg;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_out <= '{chip_reset: 1'b1, cs_n: 1'b1,
                         host_read_strobe_n: 1'b1,
                         host_write_strobe_n: 1'b1,
                         transfer_acknowledge_n: 1'b1,
                         end_of_process_n: 1'b1,
                         default: '0};
        end else begin
            dev_out <= pins_next;
        end
    end

    // Transfer progress: remaining count, buffer index, burst hold
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rem_reg      <= `SHI_COUNT_RST;
            idx_reg      <= 4'h0;
            burst_on_reg <= 1'b0;
        end else if (state_reg == SHI_ST_IDLE) begin
            burst_on_reg <= 1'b0;
            if (sw_wr && (sw_addr == `SHI_SW_DMA_COUNT)) begin
                rem_reg <= sw_wdata[4:0];
                idx_reg <= 4'h0;
            end
        end else if (abort && (state_reg == SHI_ST_DWAIT)) begin
            burst_on_reg <= 1'b0;
        end else if (byte_end && dma_reg) begin
            rem_reg      <= rem_reg - 5'h01;
            idx_reg      <= idx_reg + 4'h1;
            burst_on_reg <= cfg_reg[`SHI_CFG_BURST];
        end
    end

    // Software settings
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dev_addr_reg  <= `SHI_DEV_ADDR_RST;
            dev_wdata_reg <= `SHI_BYTE_RST;
            cfg_reg       <= `SHI_CFG_RST;
        end else if (sw_wr && (state_reg == SHI_ST_IDLE)) begin
            if (sw_addr == `SHI_SW_DEV_ADDR) begin
                dev_addr_reg <= sw_wdata[3:0];
            end
            if (sw_addr == `SHI_SW_DEV_WDATA) begin
                dev_wdata_reg <= sw_wdata[7:0];
            end
            if (sw_addr == `SHI_SW_DMA_CFG) begin
                cfg_reg <= sw_wdata[2:0];
            end
        end
    end

    // Done flag: completion in the clearing cycle wins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
        end else if (done_evt) begin
            done_reg <= 1'b1;
        end else if (sw_wr && (sw_addr == `SHI_SW_STATUS) &&
                     sw_wdata[`SHI_ST_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    // Read data sampled on the last strobe cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= `SHI_BYTE_RST;
        end else if (strobe_end && !is_wr_reg) begin
            rdata_reg <= in_reg.host_data_i;
        end
    end

    // Byte buffer for DMA; captured bytes take priority over software
    always_ff @(posedge ref_clk) begin
        if (strobe_end && !is_wr_reg && dma_reg) begin
            buf_mem[idx_reg] <= in_reg.host_data_i;
        end else if (sw_wr && buf_sel) begin
            buf_mem[sw_addr[5:2]] <= sw_wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_rdata <= 32'h0000_0000;
        end else if (sw_rd) begin
            sw_rdata <= 32'h0000_0000;
            if (buf_sel) begin
                sw_rdata[7:0] <= buf_mem[sw_addr[5:2]];
            end else begin
                unique case (sw_addr)
                    `SHI_SW_DEV_ADDR:  sw_rdata[3:0] <= dev_addr_reg;
                    `SHI_SW_DEV_WDATA: sw_rdata[7:0] <= dev_wdata_reg;
                    `SHI_SW_STATUS: begin
                        sw_rdata[`SHI_ST_BUSY]  <=
                            (state_reg != SHI_ST_IDLE);
                        sw_rdata[`SHI_ST_DONE]  <= done_reg;
                        sw_rdata[`SHI_ST_IRQ]   <= in_reg.irq;
                        sw_rdata[`SHI_ST_XREQ]  <=
                            in_reg.transfer_request;
                        sw_rdata[`SHI_ST_READY] <= in_reg.ready;
                    end
                    `SHI_SW_RDATA:     sw_rdata[7:0] <= rdata_reg;
                    `SHI_SW_DMA_CFG:   sw_rdata[2:0] <= cfg_reg;
                    `SHI_SW_DMA_COUNT: sw_rdata[4:0] <= rem_reg;
                    default:           sw_rdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            sw_rdata <= 32'h0000_0000;
        end
    end

endmodule

// [pkg/shi_cfg.svh]
`ifndef SHI_CFG_SVH
`define SHI_CFG_SVH

// Device register selects, driven on the three select pins
`define SHI_DEV_DATA        3'h0
`define SHI_DEV_INIT_CMD    3'h1
`define SHI_DEV_MODE        3'h2
`define SHI_DEV_TGT_CMD     3'h3
`define SHI_DEV_LINES_ID    3'h4
`define SHI_DEV_DMA_STAT    3'h5
`define SHI_DEV_IN_TRECV    3'h6
`define SHI_DEV_CLR_IRECV   3'h7

// Controller register byte addresses on the software port
`define SHI_SW_DEV_ADDR     8'h00
`define SHI_SW_DEV_WDATA    8'h04
`define SHI_SW_CTRL         8'h08
`define SHI_SW_STATUS       8'h0C
`define SHI_SW_RDATA        8'h10
`define SHI_SW_DMA_CFG      8'h14
`define SHI_SW_DMA_COUNT    8'h18
`define SHI_SW_BUF_BASE     8'h40
`define SHI_SW_BUF_MASK     8'hC0

// Field positions
`define SHI_CTRL_WR_GO      0
`define SHI_CTRL_RD_GO      1
`define SHI_CTRL_RST_GO     2
`define SHI_CTRL_DMA_GO     3
`define SHI_CTRL_ABORT      4
`define SHI_CFG_DIR_RD      0
`define SHI_CFG_BURST       1
`define SHI_CFG_FIN_LAST    2
`define SHI_ST_BUSY         0
`define SHI_ST_DONE         1
`define SHI_ST_IRQ          2
`define SHI_ST_XREQ         3
`define SHI_ST_READY        4

// Reset values
`define SHI_DEV_ADDR_RST    4'h0
`define SHI_BYTE_RST        8'h00
`define SHI_CFG_RST         3'h0
`define SHI_COUNT_RST       5'h00

// Timing, ns at a clock period of SHI_CLK_NS
`define SHI_CLK_NS          8
`define SHI_SETUP_NS        16
`define SHI_STB_NS          96
`define SHI_HOLD_NS         16
`define SHI_RST_NS          400
`define SHI_SETUP_CYC ((`SHI_SETUP_NS + `SHI_CLK_NS - 1) / `SHI_CLK_NS)
`define SHI_STB_CYC   ((`SHI_STB_NS + `SHI_CLK_NS - 1) / `SHI_CLK_NS)
`define SHI_HOLD_CYC  ((`SHI_HOLD_NS + `SHI_CLK_NS - 1) / `SHI_CLK_NS)
`define SHI_RST_CYC   ((`SHI_RST_NS + `SHI_CLK_NS - 1) / `SHI_CLK_NS)

`define SHI_BUF_DEPTH       16

`endif

// [pkg/shi_pkg.sv]
package shi_pkg;

    typedef enum logic [2:0] {
        SHI_ST_RST   = 3'b000,
        SHI_ST_IDLE  = 3'b001,
        SHI_ST_SETUP = 3'b010,
        SHI_ST_STB   = 3'b011,
        SHI_ST_HOLD  = 3'b100,
        SHI_ST_DWAIT = 3'b101
    } shi_state_t;

    // Pins driven toward the controller chip
    typedef struct packed {
        logic       chip_reset;
        logic       cs_n;
        logic       host_read_strobe_n;
        logic       host_write_strobe_n;
        logic       transfer_acknowledge_n;
        logic       end_of_process_n;
        logic [2:0] register_select;
        logic [7:0] host_data_o;
        logic       host_data_oe;
    } shi_dev_out_t;

    // Pins coming back from the controller chip
    typedef struct packed {
        logic [7:0] host_data_i;
        logic       transfer_request;
        logic       irq;
        logic       ready;
    } shi_dev_in_t;

endpackage

// [tb/shi_host_assertions.sv]
`timescale 1ns/1ps
module shi_host_assertions
    import shi_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         sys_rst,
    input wire logic [7:0]   sw_addr,
    input wire logic [31:0]  sw_wdata,
    input wire logic         sw_wr,
    input wire logic         sw_rd,
    input wire logic [31:0]  sw_rdata,
    input wire shi_dev_in_t  dev_in,
    input wire shi_dev_out_t dev_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic rd_n;
    logic wr_n;
    logic ack_n;
    logic quiet;
    logic req;
    assign rd_n  = dev_out.host_read_strobe_n;
    assign wr_n  = dev_out.host_write_strobe_n;
    assign ack_n = dev_out.transfer_acknowledge_n;
    assign quiet = rd_n && wr_n;
    assign req   = dev_in.transfer_request;

    property p_rst_hold;
        $fell(sys_rst) |-> dev_out.chip_reset [*8];
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("chip reset released early");
    property p_one_strobe;
        rd_n || wr_n;
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("both strobes low");
    property p_sel_src;
        !quiet |-> (dev_out.cs_n != ack_n);
    endproperty
    a_sel_src: assert property (p_sel_src)
        else $error("strobe without exactly one select");
    property p_sel_stable;
        !quiet |-> $stable(dev_out.register_select) && $stable(dev_out.cs_n);
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("select moved under strobe");
    property p_rd_len;
        $fell(rd_n) |-> ##12 $rose(rd_n);
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("read strobe length wrong");
    property p_wr_len;
        $fell(wr_n) |-> (!wr_n) [*8] ##5 $rose(wr_n);
    endproperty
    a_wr_len: assert property (p_wr_len)
        else $error("write strobe length wrong");
    property p_drive;
        !quiet |-> (dev_out.host_data_oe == !wr_n);
    endproperty
    a_drive: assert property (p_drive)
        else $error("data enable does not follow strobe");
    property p_ack_req;
        $fell(ack_n) |-> $past(req, 1) || $past(req, 2) || $past(req, 3);
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("acknowledge without request");
    property p_fin;
        !dev_out.end_of_process_n |-> !ack_n && !quiet;
    endproperty
    a_fin: assert property (p_fin)
        else $error("end of process outside a byte");
    property p_ack_end;
        $rose(ack_n) |-> $past(quiet, 2);
    endproperty
    a_ack_end: assert property (p_ack_end)
        else $error("acknowledge ended inside strobe");
    c_dma_byte: cover property ($fell(ack_n));
    c_fin: cover property (!dev_out.end_of_process_n);
    c_prog_rd: cover property ($fell(rd_n) && !dev_out.cs_n);
endmodule

// [tb/shi_chip_model.sv]
`timescale 1ns/1ps
module shi_chip_model
    import shi_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire shi_dev_out_t dev_out,
    output shi_dev_in_t       dev_in
);
    logic [7:0] regs [8];
    logic [7:0] wlog [16];
    logic [3:0] widx, ridx;
    logic [7:0] last_q, hd, dstat;
    logic       dma_on, fin_d, fin_seen, rd_d, wr_d, req, irq, rdy;
    wire        dk    = !dev_out.transfer_acknowledge_n;
    wire        cs    = !dev_out.cs_n;
    wire        rs    = !dev_out.host_read_strobe_n;
    wire        ws    = !dev_out.host_write_strobe_n;
    wire  [2:0] a     = dev_out.register_select;
    wire        end_r = rd_d && !rs;
    wire        end_w = wr_d && !ws;

    // DMA status, bit 7 down: end, request, parity, interrupt, phase,
    // busy error, ATN, ACK; the SCSI-side flags stay clear here
    assign dstat = {fin_seen, req, 1'b0, irq, 3'h0, dk};

    // Released data pins churn so a late sample cannot pass
    always_comb begin
        hd = ~last_q;
        if (rs && dk) begin
            hd = 8'hA0 + {4'h0, ridx};
        end else if (rs && cs) begin
            hd = regs[a];
            if (a == 3'h4) begin
                hd = 8'h00;
            end else if (a == 3'h5) begin
                hd = dstat;
            end
        end
    end
    assign rdy = regs[2][7] && regs[2][1] && dma_on && !fin_seen
                 && dk && !rs && !ws;
    assign dev_in = {hd, req, irq, rdy};

    always_ff @(posedge ref_clk) begin
        rd_d <= rs;
        wr_d <= ws;
        if (rs || ws) begin
            fin_d <= !dev_out.end_of_process_n;
        end
        if (dev_out.chip_reset) begin
            for (int i = 0; i < 8; i++) begin
                regs[i] <= 8'h00;
            end
            {dma_on, fin_seen, req, irq} <= 4'h0;
            widx   <= 4'h0;
            ridx   <= 4'h0;
            last_q <= 8'h00;
        end else begin
            last_q <= hd;
            // Mode stays on after end of process
            req <= regs[2][1] && dma_on && !fin_seen && !dk;
            if (end_w && cs) begin
                if (a > 3'h4) begin
                    dma_on   <= 1'b1;
                    fin_seen <= 1'b0;
                end else begin
                    regs[a] <= dev_out.host_data_o;
                end
            end
            if (end_r && cs && a == 3'h7) begin
                irq <= 1'b0;
            end
            if ((end_r || end_w) && dk) begin
                if (end_w) begin
                    wlog[widx] <= dev_out.host_data_o;
                end
                widx <= widx + {3'h0, end_w};
                ridx <= ridx + {3'h0, end_r};
                if (fin_d) begin
                    fin_seen <= 1'b1;
                    irq      <= regs[2][3];
                end
            end
        end
    end
endmodule

// [tb/shi_host_tb.sv]
`timescale 1ns/1ps
`include "shi_cfg.svh"
module shi_host_tb
    import shi_pkg::*;
;
    logic         ref_clk, sys_rst, sw_wr, sw_rd;
    logic [7:0]   sw_addr;
    logic [31:0]  sw_wdata, sw_rdata;
    shi_dev_in_t  dev_in;
    shi_dev_out_t dev_out;
    int           num_errors = 0;
    int           checks_done = 0;

    shi_host shi_host_i (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .sw_addr (sw_addr),
        .sw_wdata(sw_wdata),
        .sw_wr   (sw_wr),
        .sw_rd   (sw_rd),
        .sw_rdata(sw_rdata),
        .dev_in  (dev_in),
        .dev_out (dev_out)
    );
    shi_chip_model shi_chip_model_i (
        .ref_clk(ref_clk),
        .dev_out(dev_out),
        .dev_in (dev_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic close_out;
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        @(posedge ref_clk);
        d = sw_rdata;
    endtask
    task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        sw_read(a, d);
        check(d, e);
    endtask
    task automatic st_bit(input int b, input logic e);
        logic [31:0] s;
        sw_read(`SHI_SW_STATUS, s);
        check(32'(s[b]), 32'(e));
    endtask
    task automatic wait_idle;
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 300 && s[`SHI_ST_BUSY]; i++) begin
            sw_read(`SHI_SW_STATUS, s);
        end
        check(32'(s[`SHI_ST_BUSY]), 32'h0);
    endtask
    task automatic chip_go(input logic [2:0] a, input logic [7:0] d,
                           input logic [31:0] go);
        sw_write(`SHI_SW_DEV_ADDR, {29'h0, a});
        sw_write(`SHI_SW_DEV_WDATA, {24'h0, d});
        sw_write(`SHI_SW_CTRL, go);
        wait_idle;
    endtask
    task automatic chip_wr(input logic [2:0] a, input logic [7:0] d);
        chip_go(a, d, 32'h1);
    endtask
    task automatic chip_rd(input logic [2:0] a, input logic [7:0] e);
        chip_go(a, 8'h00, 32'h2);
        expect_rd(`SHI_SW_RDATA, {24'h0, e});
    endtask
    task automatic dma(input logic [31:0] cfg, input logic [31:0] cnt);
        sw_write(`SHI_SW_DMA_CFG, cfg);
        sw_write(`SHI_SW_DMA_COUNT, cnt);
        sw_write(`SHI_SW_CTRL, 32'h8);
    endtask
    function automatic logic [7:0] buf_a(input int i);
        return `SHI_SW_BUF_BASE + 8'(4 * i);
    endfunction

    initial begin
        sys_rst  = 1'b1;
        sw_addr  = 8'h00;
        sw_wdata = 32'h0;
        sw_wr    = 1'b0;
        sw_rd    = 1'b0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check(32'(dev_out.chip_reset), 32'h1);
        expect_rd(8'h30, 32'h0);
        wait_idle;
        check(32'(dev_out.chip_reset), 32'h0);
        for (int i = 1; i < 4; i++) begin
            chip_wr(3'(i), 8'h50 + 8'(i));
        end
        for (int i = 1; i < 4; i++) begin
            chip_rd(3'(i), 8'h50 + 8'(i));
        end
        chip_wr(3'h0, 8'h3C);
        chip_rd(3'h0, 8'h3C);
        chip_wr(3'h4, 8'h81);
        chip_rd(3'h4, 8'h00);
        sw_write(`SHI_SW_CTRL, 32'h4);
        wait_idle;
        chip_rd(3'h2, 8'h00);
        // Normal send of four bytes
        for (int i = 0; i < 4; i++) begin
            sw_write(buf_a(i), 32'hC1 + i);
        end
        chip_wr(3'h2, 8'h02);
        chip_wr(3'h5, 8'h00);
        dma(32'h0, 32'h4);
        wait_idle;
        for (int i = 0; i < 4; i++) begin
            check({24'h0, shi_chip_model_i.wlog[i]}, 32'hC1 + i);
        end
        expect_rd(`SHI_SW_DMA_COUNT, 32'h0);
        // Burst receive, end of process on the last byte
        chip_wr(3'h2, 8'h8A);
        chip_wr(3'h7, 8'h00);
        dma(32'h7, 32'h3);
        wait_idle;
        for (int i = 0; i < 3; i++) begin
            expect_rd(buf_a(i), 32'hA0 + i);
        end
        st_bit(`SHI_ST_XREQ, 1'b0);
        st_bit(`SHI_ST_IRQ, 1'b1);
        chip_rd(3'h5, 8'h90);
        chip_rd(3'h7, 8'h00);
        st_bit(`SHI_ST_IRQ, 1'b0);
        // DMA mode off: no request comes, so abort the wait
        chip_wr(3'h2, 8'h00);
        sw_write(`SHI_SW_STATUS, 32'h2);
        dma(32'h0, 32'h2);
        repeat (20) @(posedge ref_clk);
        check(32'(dev_in.transfer_request), 32'h0);
        sw_write(`SHI_SW_CTRL, 32'h10);
        wait_idle;
        st_bit(`SHI_ST_DONE, 1'b0);
        expect_rd(`SHI_SW_DMA_COUNT, 32'h2);
        close_out;
    end

    initial begin
        repeat (25000) @(posedge ref_clk);
        num_errors++;
        close_out;
    end
endmodule

bind shi_host shi_host_assertions shi_host_assertions_i (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .sw_addr (sw_addr),
    .sw_wdata(sw_wdata),
    .sw_wr   (sw_wr),
    .sw_rd   (sw_rd),
    .sw_rdata(sw_rdata),
    .dev_in  (dev_in),
    .dev_out (dev_out)
);
